// ### rtl/buck1_control_registers.sv
// buck1 control register bank behind an axi4-lite slave
// assumes one clock; otp image is stable while aresetn is low and a cycle after
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ns
module buck1_control_registers (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic aclken,
  input wire logic [39:0] otp_image,
  input wire logic [buck1_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [buck1_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [buck1_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [buck1_regs_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output buck1_regs_pkg::buck1_cfg_s buck1_cfg,
  output logic step_tick
);
  import buck1_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencing: otp load runs on every enabled cycle of reset
  logic load;
  assign load = !aresetn;

  ////////////////////////////////////////////////////////////////////////////
  // write channel capture, address and data accepted in either order
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] aw_idx_r;
  logic [7:0] w_data_r;
  logic w_lane_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic do_write;
  reg_wr_s wr;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  assign do_write = aw_held_r && w_held_r && !bvalid_r;

  // address latch, word index from byte address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      aw_idx_r <= 8'h00;
    end else if (aclken) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_idx_r <= s_axi_awaddr[9:2];
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // data latch, only byte lane 0 carries register bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
    end else if (aclken) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // address decode for writes
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == IDX_STBY) || (idx == IDX_SLEEP) || (idx == IDX_MODE) ||
             (idx == IDX_CONF) || (idx == IDX_CONF_ALT);
  endfunction

  always_comb begin
    wr.idx = aw_idx_r;
    wr.data = w_data_r;
    wr.we = do_write && w_lane_r && mapped(aw_idx_r);
  end

  // write response, unmapped index answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (aclken) begin
      if (do_write) begin
        bvalid_r <= 1'b1;
        bresp_r <= mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // register storage; both configuration offsets alias one register
  logic [7:0] stby_q;
  logic [7:0] sleep_q;
  logic [7:0] mode_q;
  logic [7:0] conf_q;

  buck1_field_reg #(.MASK(MASK_VOLT)) u_stby (
    .aclk(aclk),
    .aclken(aclken),
    .load(load),
    .otp_value(otp_image[7:0]),
    .we(wr.we && wr.idx == IDX_STBY),
    .wdata(wr.data),
    .q(stby_q)
  );

  buck1_field_reg #(.MASK(MASK_VOLT)) u_sleep (
    .aclk(aclk),
    .aclken(aclken),
    .load(load),
    .otp_value(otp_image[15:8]),
    .we(wr.we && wr.idx == IDX_SLEEP),
    .wdata(wr.data),
    .q(sleep_q)
  );

  // off behaviour bit has a fixed zero default, so otp feeds only bits 3:0
  buck1_field_reg #(.MASK(MASK_MODE)) u_mode (
    .aclk(aclk),
    .aclken(aclken),
    .load(load),
    .otp_value({4'h0, otp_image[19:16]}),
    .we(wr.we && wr.idx == IDX_MODE),
    .wdata(wr.data),
    .q(mode_q)
  );

  // phase clock defaults to zero; step rate, frequency and limit come from otp
  buck1_field_reg #(.MASK(MASK_CONF)) u_conf (
    .aclk(aclk),
    .aclken(aclken),
    .load(load),
    .otp_value(otp_image[39:32] & 8'h4D),
    .we(wr.we && (wr.idx == IDX_CONF || wr.idx == IDX_CONF_ALT)),
    .wdata(wr.data),
    .q(conf_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decoded fields toward the regulator
  always_comb begin
    buck1_cfg.standby_code = stby_q[4:0];
    buck1_cfg.sleep_code = sleep_q[4:0];
    buck1_cfg.off_behaviour = mode_q[5]; // 0 off, 1 sleep
    buck1_cfg.switch_mode = mode_q[3:0];
    buck1_cfg.step_rate = conf_q[6];
    buck1_cfg.phase_clock = conf_q[5:4];
    buck1_cfg.switch_frequency = conf_q[3:2];
    buck1_cfg.current_limit = conf_q[0]; // 0 is 4 A, 1 is 2 A
  end

  ////////////////////////////////////////////////////////////////////////////
  // voltage-stepping pacer: one pulse per 25 mV step at the selected rate
  logic [8:0] step_cnt_r;
  logic [8:0] step_last;
  logic step_tick_r;
  assign step_last = conf_q[6] ? 9'(STEP_SLOW_CYC - 1) : 9'(STEP_FAST_CYC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_cnt_r <= 9'h000;
      step_tick_r <= 1'b0;
    end else if (aclken) begin
      if (step_cnt_r >= step_last) begin
        step_cnt_r <= 9'h000;
        step_tick_r <= 1'b1;
      end else begin
        step_cnt_r <= step_cnt_r + 9'h001;
        step_tick_r <= 1'b0;
      end
    end
  end
  assign step_tick = step_tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one read at a time, data from a register
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] rd_idx;
  assign s_axi_arready = !rvalid_r;
  assign rd_idx = s_axi_araddr[9:2];

  // reserved bits are already zero in storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (aclken) begin
      if (s_axi_arvalid && !rvalid_r) begin
        rvalid_r <= 1'b1;
        rresp_r <= mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
        unique case (rd_idx)
          IDX_STBY: rdata_r <= {24'h000000, stby_q};
          IDX_SLEEP: rdata_r <= {24'h000000, sleep_q};
          IDX_MODE: rdata_r <= {24'h000000, mode_q};
          IDX_CONF, IDX_CONF_ALT: rdata_r <= {24'h000000, conf_q};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule // buck1_control_registers

// ### rtl/buck1_field_reg.sv
// one 8-bit register with a writable-bit mask and an otp-loaded reset value
// assumes otp_value is stable while load is high
`timescale 1ns/1ns
module buck1_field_reg #(
  parameter logic [7:0] MASK = 8'hFF
) (
  input wire logic aclk,
  input wire logic aclken,
  input wire logic load,
  input wire logic [7:0] otp_value,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] q
);
  logic [7:0] value_r;
  // reset is not asynchronous here, so load is a clocked take of the otp value
  always_ff @(posedge aclk) begin
    if (aclken) begin
      if (load) begin
        value_r <= otp_value & MASK;
      end else if (we) begin
        value_r <= wdata & MASK;
      end
    end
  end
  assign q = value_r;
endmodule // buck1_field_reg

// ### rtl/buck1_regs_pkg.sv
// package: offsets, field layout and bus types for the buck1 control register bank
// assumes an axi4-lite master with 32-bit data and byte addresses
package buck1_regs_pkg;
  // printed offsets are not all multiples of four: they are word indices
  localparam logic [7:0] IDX_SLEEP = 8'h22;
  localparam logic [7:0] IDX_MODE = 8'h23;
  localparam logic [7:0] IDX_CONF = 8'h24;
  localparam logic [7:0] IDX_CONF_ALT = 8'h32;
  localparam logic [7:0] IDX_STBY = 8'h21;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  // writable-bit masks, reserved bits are zero here
  localparam logic [7:0] MASK_VOLT = 8'h1F;
  localparam logic [7:0] MASK_MODE = 8'h2F;
  localparam logic [7:0] MASK_CONF = 8'h7D;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // step rate timing, one 25 mV step per period
  localparam int STEP_FAST_NS = 2000;
  localparam int STEP_SLOW_NS = 4000;
  localparam int CLK_NS = 10;
  localparam int STEP_FAST_CYC = STEP_FAST_NS / CLK_NS;
  localparam int STEP_SLOW_CYC = STEP_SLOW_NS / CLK_NS;

  // one register write request
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
    logic we;
  } reg_wr_s;

  // decoded configuration seen by the regulator
  typedef struct packed {
    logic [4:0] standby_code;
    logic [4:0] sleep_code;
    logic off_behaviour;
    logic [3:0] switch_mode;
    logic step_rate;
    logic [1:0] phase_clock;
    logic [1:0] switch_frequency;
    logic current_limit;
  } buck1_cfg_s;
endpackage

// ### tb/buck1_control_registers_monitor.sv
// checker for the buck1 register bank: otp loads, reserved bits, bus answers, step tick
// assumes aclken stays high, so each aclk edge is one counted cycle
`timescale 1ns/1ns
module buck1_control_registers_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [39:0] otp_image,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [buck1_regs_pkg::DATA_W-1:0] s_axi_rdata,
  input wire buck1_regs_pkg::buck1_cfg_s buck1_cfg,
  input wire logic step_tick
);
  import buck1_regs_pkg::*;
  int unsigned gap_r;
  logic run_r;
  ////////////////////////////////////////////////////////////////////////
  // cycles since last tick; a rate change voids the gap, a restart is legal there
  always_ff @(posedge aclk) begin
    if (!aresetn || $changed(buck1_cfg.step_rate)) run_r <= 1'b0;
    else if (step_tick) run_r <= 1'b1;
    gap_r <= step_tick ? 1 : gap_r + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_STBY_LOAD: assert property (
    $rose(aresetn) |-> buck1_cfg.standby_code == otp_image[4:0]) else $error("standby load");
  AST_SLEEP_LOAD: assert property (
    $rose(aresetn) |-> buck1_cfg.sleep_code == otp_image[12:8]) else $error("sleep load");
  AST_MODE_LOAD: assert property (
    $rose(aresetn) |-> {buck1_cfg.off_behaviour, buck1_cfg.switch_mode} == {1'b0,
    otp_image[19:16]}) else $error("mode load");
  AST_CONF_LOAD: assert property (
    $rose(aresetn) |-> {buck1_cfg.step_rate, buck1_cfg.phase_clock, buck1_cfg.switch_frequency,
    buck1_cfg.current_limit} == {otp_image[38], 2'h0, otp_image[35:34], otp_image[32]})
    else $error("config load");
  AST_STEP_GAP: assert property (
    step_tick && run_r && $stable(buck1_cfg.step_rate) |->
    gap_r == (buck1_cfg.step_rate ? 400 : 200)) else $error("step period");
  AST_RESV_ZERO: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0) else $error("reserved bits set");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid) else $error("read not answered");
  AST_RVALID_HOLD: assert property (
    $fell(s_axi_rvalid) |-> $past(s_axi_rready)) else $error("read answer dropped");
  AST_BVALID_HOLD: assert property (
    $fell(s_axi_bvalid) |-> $past(s_axi_bready)) else $error("write answer dropped");
  // main scenarios reached
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
  COV_READ: cover property (s_axi_rvalid && s_axi_rready);
  COV_SLOW: cover property (step_tick && run_r && buck1_cfg.step_rate);
endmodule // buck1_control_registers_monitor
////////////////////////////////////////////////////////////////////////
bind buck1_control_registers buck1_control_registers_monitor buck1_control_registers_monitor_i (
  .aclk(aclk), .aresetn(aresetn), .otp_image(otp_image), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .buck1_cfg(buck1_cfg),
  .step_tick(step_tick));

// ### tb/buck1_control_registers_test.sv
// testbench for the buck1 register bank: axi4-lite tasks, one task per scenario
// assumes the monitor is bound to the design; aclken and prot stay fixed
`timescale 1ns/1ns
module buck1_control_registers_test;
  import buck1_regs_pkg::*;
  localparam logic [39:0] OTP = 40'hFF000AF6EB;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] awaddr = 10'h0, araddr = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, step_tick;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  buck1_cfg_s cfg;
  int num_errors = 0, n_compared = 0;
  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  always #5 aclk = ~aclk;
  buck1_control_registers buck1_control_registers_i (
    .aclk(aclk), .aresetn(aresetn), .aclken(1'b1), .otp_image(OTP), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .buck1_cfg(cfg), .step_tick(step_tick));
  ////////////////////////////////////////////////////////////////////////
  // compare, count, report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // write: both channels offered together, each released once taken
  // outputs are sampled at the falling edge, where they have settled, and acted on at the next rise
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    logic seen_aw;
    logic seen_w;
    logic seen_b;
    logic [1:0] got_resp;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      seen_aw = awready;
      seen_w = wready;
      seen_b = bvalid;
      got_resp = bresp;
      @(posedge aclk);
      if (seen_aw) awvalid <= 1'b0;
      if (seen_w) wvalid <= 1'b0;
    end while (!seen_b);
    chk({30'h0, got_resp}, {30'h0, er});
    bready <= 1'b0;
  endtask
  // read and judge data and response at the answering edge
  task automatic rd(input logic [9:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic seen_ar;
    logic seen_r;
    logic [31:0] got_d;
    logic [1:0] got_resp;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      seen_ar = arready;
      seen_r = rvalid;
      got_d = rdata;
      got_resp = rresp;
      @(posedge aclk);
      if (seen_ar) arvalid <= 1'b0;
    end while (!seen_r);
    chk(got_d, ed);
    chk({30'h0, got_resp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // reset values come from the otp image, masked to the bits that otp feeds
  task automatic t_reset();
    chk(cfg, {5'h0B, 5'h16, 1'b0, 4'hA, 1'b1, 2'h0, 2'h3, 1'b1});
    rd(10'h084, 32'h0B, RESP_OKAY);
    rd(10'h088, 32'h16, RESP_OKAY);
    rd(10'h08C, 32'h0A, RESP_OKAY);
    rd(10'h090, 32'h4D, RESP_OKAY);
    rd(10'h0C8, 32'h4D, RESP_OKAY);
  endtask
  // all ones then zeros into each register; reserved and upper bits must not stick
  task automatic t_rw();
    logic [9:0] adr [4] = '{10'h084, 10'h088, 10'h08C, 10'h090};
    logic [7:0] msk [4] = '{8'h1F, 8'h1F, 8'h2F, 8'h7D};
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rd(adr[i], {24'h0, msk[i]}, RESP_OKAY);
    end
    chk(cfg, 32'h1FFFFF);
    for (int i = 0; i < 4; i++) begin
      wr(adr[i], 32'hFFFFFF00, 4'hF, RESP_OKAY);
      rd(adr[i], 32'h0, RESP_OKAY);
    end
    chk(cfg, 32'h0);
    wr(10'h084, 32'h35, 4'hF, RESP_OKAY);
    wr(10'h08C, 32'h25, 4'hF, RESP_OKAY);
    wr(10'h0C8, 32'h41, 4'hF, RESP_OKAY);
    rd(10'h090, 32'h41, RESP_OKAY);
    chk(cfg, 32'h150561);
  endtask
  // unmapped place and a write with its byte strobe off
  task automatic t_err();
    wr(10'h000, 32'h1, 4'hF, RESP_SLVERR);
    rd(10'h000, 32'h0, RESP_SLVERR);
    wr(10'h088, 32'h1F, 4'h0, RESP_OKAY);
    rd(10'h088, 32'h0, RESP_OKAY);
  endtask
  // skip two ticks after the rate write so a restart cannot skew the gap
  task automatic t_step(input logic [31:0] c, input logic [31:0] exp);
    int n;
    wr(10'h090, c, 4'hF, RESP_OKAY);
    repeat (2) do @(negedge aclk); while (!step_tick);
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (!step_tick);
    chk(n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_rw();
    t_err();
    t_step(32'h0, 32'hC8);
    t_step(32'h40, 32'h190);
    conclude();
  end
  // the run needs about 2000 cycles; give it fifteen times that
  initial begin
    #300000;
    num_errors++;
    conclude();
  end
endmodule // buck1_control_registers_test
